// ### rtl/mrd_rx_dma.v
// Receive DMA engine with descriptor manager, receive FIFO and bus master.
`timescale 1ns/1ps
`include "mrd_defs.vh"
module mrd_rx_dma #(
    parameter FIFO_WORDS = `MRD_FIFO_WORDS,
    parameter FIFO_AW = `MRD_FIFO_AW
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_ce,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire i_rx_word_valid,
    input wire [31:0] i_rx_word,
    input wire i_rx_word_last,
    input wire [13:0] i_rx_frame_len,
    input wire [15:0] i_rx_addr_status,
    output wire o_rx_word_ready,
    output wire [1:0] o_rx_offset,
    input wire [5:0] i_tx_fifo_space,
    input wire i_tx_next_short,
    input wire i_tx_data_busy,
    input wire i_tx_desc_rd_req,
    input wire i_tx_desc_wr_req,
    output wire o_tx_data_req,
    output wire [2:0] o_tx_grant,
    input wire i_hgrant,
    input wire i_hready,
    input wire [1:0] i_hresp,
    input wire [31:0] i_hrdata,
    output wire o_hbusreq,
    output reg [1:0] o_htrans,
    output reg [31:0] o_haddr,
    output reg o_hwrite,
    output reg [2:0] o_hburst,
    output wire [2:0] o_hsize,
    output reg [31:0] o_hwdata
);
    localparam S_IDLE = 2'h0;
    localparam S_DRD = 2'h1;
    localparam S_DAT = 2'h2;
    localparam S_DWR = 2'h3;

    // ****************************************
    // Registers and state
    // ****************************************
    reg [31:0] cfg_reg;
    reg [31:0] qbase_reg;
    reg [9:0] didx_reg;
    reg [2:0] stat_reg;
    reg ack_reg;
    reg [1:0] st_reg;
    reg gap_reg;
    reg [32:0] mem [0:FIFO_WORDS-1];
    reg [FIFO_AW-1:0] wp_reg;
    reg [FIFO_AW-1:0] rp_reg;
    reg [FIFO_AW:0] cnt_reg;
    reg buf_valid_reg;
    reg [29:0] buf_addr_reg;
    reg buf_wrap_reg;
    reg [5:0] used_reg;
    reg sof_reg;
    reg ended_reg;
    reg close_reg;
    reg eof_close_reg;
    reg pend_reg;
    reg [13:0] flen_reg;
    reg [15:0] fstat_reg;
    reg [1:0] fofs_reg;
    reg [2:0] arem_reg;
    reg [2:0] blen_reg;
    reg dp_reg;
    reg dp_last_reg;
    reg dp_write_reg;
    reg beat_reg;
    wire [5:0] grant;
    wire [5:0] req;
    wire [31:0] dptr;
    wire push;
    wire pop;
    wire addr_acc;
    wire beat_done;
    wire op_done;
    wire rx_en;
    wire data_ready;
    reg [2:0] blen;
    reg [31:0] status_word;
    reg [13:0] len_adj;
    integer j;
    wire [1:0] haddr_next_lo;
    wire [31:0] room_wide;
    wire [31:0] cnt_wide;

    function [2:0] min3;
        input [2:0] a;
        input [5:0] b;
        input [5:0] c;
        begin
            min3 = a;
            if ({3'h0, min3} > b) begin
                min3 = b[2:0];
            end
            if ({3'h0, min3} > c) begin
                min3 = c[2:0];
            end
        end
    endfunction

    // ****************************************
    // Register bus slave
    // ****************************************
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign rx_en = cfg_reg[`MRD_CFG_RXEN];
    assign o_rx_offset = cfg_reg[`MRD_CFG_OFS_HI:`MRD_CFG_OFS_LO];
    assign dptr = qbase_reg + {19'h00000, didx_reg, 3'h0};

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else if (i_ce) begin
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
            if (i_avs_read & ~ack_reg) begin
                case (i_avs_address)
                    `MRD_REG_CONFIG: o_avs_readdata <= cfg_reg;
                    `MRD_REG_QPTR: o_avs_readdata <= dptr;
                    `MRD_REG_STATUS: o_avs_readdata <= {29'h00000000, stat_reg};
                    `MRD_REG_LEVEL: o_avs_readdata <= {24'h000000, st_reg,
                                                       cnt_reg};
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Receive FIFO
    // ****************************************
    // Hold off a new frame until the previous frame status has been written
    assign o_rx_word_ready = rx_en & (cnt_reg != FIFO_WORDS) & ~pend_reg;
    assign push = i_rx_word_valid & o_rx_word_ready;
    assign addr_acc = (o_htrans != `MRD_HTRANS_IDLE) & i_hready;
    assign pop = addr_acc & (st_reg == S_DAT);

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wp_reg <= {FIFO_AW{1'b0}};
            rp_reg <= {FIFO_AW{1'b0}};
            cnt_reg <= {(FIFO_AW+1){1'b0}};
            pend_reg <= 1'b0;
            flen_reg <= 14'h0000;
            fstat_reg <= 16'h0000;
        end else if (i_ce) begin
            if (push) begin
                mem[wp_reg] <= {i_rx_word_last, i_rx_word};
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            if (push & ~pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop & ~push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (push & i_rx_word_last) begin
                pend_reg <= 1'b1;
                flen_reg <= i_rx_frame_len;
                fstat_reg <= i_rx_addr_status;
            end else if (op_done & (st_reg == S_DWR) & eof_close_reg) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Burst sizing and status word
    // ****************************************
    always @* begin
        blen = min3(3'h4 - {1'b0, haddr_next_lo}, room_wide[5:0], cnt_wide[5:0]);
        for (j = `MRD_BURST_MAX - 1; j >= 0; j = j - 1) begin
            if (j < blen && mem[rp_reg + j[FIFO_AW-1:0]][32]) begin
                blen = j[2:0] + 3'h1;
            end
        end
    end

    // Word slot within the sixteen-byte line, so a burst stops at its end
    assign haddr_next_lo = buf_addr_reg[1:0] + used_reg[1:0];
    assign room_wide = `MRD_BUF_WORDS - {26'h0, used_reg};
    assign cnt_wide = {{(31-FIFO_AW){1'b0}}, cnt_reg};

    always @* begin
        len_adj = cfg_reg[`MRD_CFG_NOFCS] ? flen_reg - `MRD_FCS_BYTES : flen_reg;
        status_word = 32'h00000000;
        status_word[`MRD_SW_SOF] = sof_reg;
        if (sof_reg) begin
            status_word[13:12] = fofs_reg;
        end
        if (eof_close_reg) begin
            status_word[31:16] = fstat_reg;
            status_word[`MRD_SW_RSVD] = 1'b0;
            status_word[`MRD_SW_EOF] = 1'b1;
            status_word[11:0] = len_adj[11:0];
            if (cfg_reg[`MRD_CFG_JUMBO]) begin
                status_word[13:12] = len_adj[13:12];
            end
        end
    end

    // ****************************************
    // Arbitration
    // ****************************************
    // Transmit request threshold depends on the size of the next transfer
    assign o_tx_data_req = i_tx_next_short ? (i_tx_fifo_space >= `MRD_TX_SHORT_SPACE) :
                           (i_tx_fifo_space >= `MRD_TX_REQ_SPACE);
    // Four waiting words or a complete frame end start a data burst
    assign data_ready = (cnt_reg >= `MRD_RX_REQ_WORDS) | (pend_reg & (cnt_reg != 0));
    assign req[`MRD_OP_RX_DESC_WR] = (st_reg == S_DWR) |
                                     ((st_reg == S_IDLE) & ~gap_reg & close_reg);
    assign req[`MRD_OP_RX_DESC_RD] = (st_reg == S_DRD) |
        ((st_reg == S_IDLE) & ~gap_reg & ~close_reg & ~buf_valid_reg & (cnt_reg != 0) &
         ~stat_reg[`MRD_ST_BNA]);
    assign req[`MRD_OP_TX_DATA_RD] = o_tx_data_req | i_tx_data_busy;
    assign req[`MRD_OP_RX_DATA_WR] = (st_reg == S_DAT) |
        ((st_reg == S_IDLE) & ~gap_reg & ~close_reg & buf_valid_reg & data_ready);
    assign req[`MRD_OP_TX_DESC_RD] = i_tx_desc_rd_req;
    assign req[`MRD_OP_TX_DESC_WR] = i_tx_desc_wr_req;
    assign o_tx_grant = {grant[`MRD_OP_TX_DESC_WR], grant[`MRD_OP_TX_DESC_RD],
                         grant[`MRD_OP_TX_DATA_RD]};

    mrd_arbiter #(
        .N(6)
    ) u_arb (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_req(req),
        .o_grant(grant)
    );

    // ****************************************
    // Bus master and descriptor manager
    // ****************************************
    assign o_hsize = `MRD_HSIZE_WORD;
    assign o_hbusreq = (st_reg != S_IDLE);
    assign beat_done = dp_reg & i_hready;
    assign op_done = beat_done & dp_last_reg;

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cfg_reg <= `MRD_CONFIG_RESET;
            qbase_reg <= `MRD_QPTR_RESET;
            didx_reg <= 10'h000;
            stat_reg <= 3'h0;
            st_reg <= S_IDLE;
            gap_reg <= 1'b0;
            buf_valid_reg <= 1'b0;
            buf_addr_reg <= 30'h00000000;
            buf_wrap_reg <= 1'b0;
            used_reg <= 6'h00;
            sof_reg <= 1'b1;
            ended_reg <= 1'b0;
            close_reg <= 1'b0;
            eof_close_reg <= 1'b0;
            fofs_reg <= 2'h0;
            arem_reg <= 3'h0;
            blen_reg <= 3'h0;
            dp_reg <= 1'b0;
            dp_last_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            beat_reg <= 1'b0;
            o_htrans <= `MRD_HTRANS_IDLE;
            o_haddr <= 32'h00000000;
            o_hwrite <= 1'b0;
            o_hburst <= `MRD_HBURST_SINGLE;
            o_hwdata <= 32'h00000000;
        end else if (i_ce) begin
            gap_reg <= op_done;
            if (i_avs_write & ack_reg) begin
                case (i_avs_address)
                    `MRD_REG_CONFIG: cfg_reg <= i_avs_writedata;
                    `MRD_REG_QPTR: begin
                        qbase_reg <= {i_avs_writedata[31:2], 2'h0};
                        didx_reg <= 10'h000;
                    end
                    default: ;
                endcase
            end
            // Hardware events win over a same-cycle software clear
            stat_reg <= stat_reg & ~((i_avs_write & ack_reg &
                        (i_avs_address == `MRD_REG_STATUS)) ? i_avs_writedata[2:0] : 3'h0);
            if (beat_done & (i_hresp != `MRD_HRESP_OKAY)) begin
                stat_reg[`MRD_ST_BUSERR] <= 1'b1;
            end
            if (op_done & (st_reg == S_DRD) & i_hrdata[`MRD_D0_USED]) begin
                stat_reg[`MRD_ST_BNA] <= 1'b1;
            end
            if (op_done & (st_reg == S_DWR) & eof_close_reg) begin
                stat_reg[`MRD_ST_FRAME] <= 1'b1;
            end
            // Launch an operation once both grants are held
            if ((st_reg == S_IDLE) & ~gap_reg & i_hgrant & i_hready) begin
                if (grant[`MRD_OP_RX_DESC_WR] & close_reg) begin
                    st_reg <= S_DWR;
                    o_htrans <= `MRD_HTRANS_NONSEQ;
                    o_haddr <= dptr;
                    o_hwrite <= 1'b1;
                    o_hburst <= `MRD_HBURST_INCR;
                    arem_reg <= 3'h2;
                    beat_reg <= 1'b0;
                end else if (grant[`MRD_OP_RX_DESC_RD] & req[`MRD_OP_RX_DESC_RD]) begin
                    st_reg <= S_DRD;
                    o_htrans <= `MRD_HTRANS_NONSEQ;
                    o_haddr <= dptr;
                    o_hwrite <= 1'b0;
                    o_hburst <= `MRD_HBURST_SINGLE;
                    arem_reg <= 3'h1;
                end else if (grant[`MRD_OP_RX_DATA_WR] & req[`MRD_OP_RX_DATA_WR]) begin
                    st_reg <= S_DAT;
                    o_htrans <= `MRD_HTRANS_NONSEQ;
                    o_haddr <= {buf_addr_reg + {24'h000000, used_reg}, 2'h0};
                    o_hwrite <= 1'b1;
                    o_hburst <= (blen == 3'h4) ? `MRD_HBURST_INCR4 :
                                (blen == 3'h1) ? `MRD_HBURST_SINGLE : `MRD_HBURST_INCR;
                    arem_reg <= blen;
                    blen_reg <= blen;
                end
            end
            if (addr_acc) begin
                dp_reg <= 1'b1;
                dp_last_reg <= (arem_reg == 3'h1);
                dp_write_reg <= o_hwrite;
                arem_reg <= arem_reg - 3'h1;
                if (arem_reg == 3'h1) begin
                    o_htrans <= `MRD_HTRANS_IDLE;
                end else begin
                    o_htrans <= `MRD_HTRANS_SEQ;
                    o_haddr <= o_haddr + 32'h00000004;
                end
                if (st_reg == S_DAT) begin
                    o_hwdata <= mem[rp_reg][31:0];
                    if (mem[rp_reg][32]) begin
                        ended_reg <= 1'b1;
                    end
                end else if (st_reg == S_DWR) begin
                    beat_reg <= 1'b1;
                    o_hwdata <= beat_reg ? status_word :
                                {buf_addr_reg, buf_wrap_reg, 1'b1};
                end
            end else if (beat_done) begin
                dp_reg <= 1'b0;
            end
            if (op_done) begin
                st_reg <= S_IDLE;
                case (st_reg)
                    S_DRD: begin
                        // An owned buffer is not taken; BNA stops descriptor reads at this entry until software clears it
                        if (~i_hrdata[`MRD_D0_USED]) begin
                            buf_valid_reg <= 1'b1;
                            buf_addr_reg <= i_hrdata[31:2];
                            buf_wrap_reg <= i_hrdata[`MRD_D0_WRAP];
                            used_reg <= 6'h00;
                            if (sof_reg) begin
                                fofs_reg <= o_rx_offset;
                            end
                        end
                    end
                    S_DAT: begin
                        used_reg <= used_reg + {3'h0, blen_reg};
                        if (ended_reg | ((used_reg + {3'h0, blen_reg}) == `MRD_BUF_WORDS)) begin
                            close_reg <= 1'b1;
                            eof_close_reg <= ended_reg;
                        end
                    end
                    S_DWR: begin
                        close_reg <= 1'b0;
                        buf_valid_reg <= 1'b0;
                        ended_reg <= 1'b0;
                        eof_close_reg <= 1'b0;
                        sof_reg <= eof_close_reg;
                        if (buf_wrap_reg | (didx_reg == `MRD_DESC_COUNT - 1)) begin
                            didx_reg <= 10'h000;
                        end else begin
                            didx_reg <= didx_reg + 10'h001;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule // mrd_rx_dma

// ### common/mrd_defs.vh
// Constants for the receive DMA engine: offsets, fields, resets, thresholds.
`ifndef MRD_DEFS_VH
`define MRD_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define MRD_REG_CONFIG 4'h0
`define MRD_REG_QPTR 4'h4
`define MRD_REG_STATUS 4'h8
`define MRD_REG_LEVEL 4'hC
`define MRD_CONFIG_RESET 32'h00000000
`define MRD_QPTR_RESET 32'h00000000
// ****************************************
// Network configuration fields
// ****************************************
`define MRD_CFG_RXEN 0
`define MRD_CFG_JUMBO 3
`define MRD_CFG_OFS_LO 14
`define MRD_CFG_OFS_HI 15
`define MRD_CFG_NOFCS 17
// ****************************************
// Status register fields
// ****************************************
`define MRD_ST_BNA 0
`define MRD_ST_BUSERR 1
`define MRD_ST_FRAME 2
// ****************************************
// FIFO, buffer and descriptor geometry
// ****************************************
`define MRD_FIFO_BYTES 128
`define MRD_FIFO_WORDS 32
`define MRD_FIFO_AW 5
`define MRD_RX_REQ_WORDS 4
`define MRD_RX_REQ_SPACE 28
`define MRD_TX_REQ_SPACE 4
`define MRD_TX_SHORT_SPACE 27
`define MRD_BUF_WORDS 32
`define MRD_BURST_MAX 4
`define MRD_DESC_COUNT 1024
`define MRD_D0_USED 0
`define MRD_D0_WRAP 1
`define MRD_SW_EOF 15
`define MRD_SW_SOF 14
`define MRD_SW_RSVD 27
`define MRD_FCS_BYTES 14'h0004
// ****************************************
// System bus encodings
// ****************************************
`define MRD_HTRANS_IDLE 2'h0
`define MRD_HTRANS_NONSEQ 2'h2
`define MRD_HTRANS_SEQ 2'h3
`define MRD_HBURST_SINGLE 3'h0
`define MRD_HBURST_INCR 3'h1
`define MRD_HBURST_INCR4 3'h3
`define MRD_HSIZE_WORD 3'h2
`define MRD_HRESP_OKAY 2'h0
// ****************************************
// Arbiter request slots, highest priority first
// ****************************************
`define MRD_OP_RX_DESC_WR 0
`define MRD_OP_RX_DESC_RD 1
`define MRD_OP_TX_DATA_RD 2
`define MRD_OP_RX_DATA_WR 3
`define MRD_OP_TX_DESC_RD 4
`define MRD_OP_TX_DESC_WR 5
`endif

// ### rtl/mrd_arbiter.v
// Fixed-priority bus arbiter for the six DMA operation types.
`timescale 1ns/1ps
module mrd_arbiter #(
    parameter N = 6
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_ce,
    input wire [N-1:0] i_req,
    output wire [N-1:0] o_grant
);
    reg [N-1:0] grant_reg;
    reg [N-1:0] grant_next;

    // Lowest index wins
    function [N-1:0] pick;
        input [N-1:0] req;
        integer k;
        begin
            pick = {N{1'b0}};
            for (k = N - 1; k >= 0; k = k - 1) begin
                if (req[k]) begin
                    pick = {N{1'b0}};
                    pick[k] = 1'b1;
                end
            end
        end
    endfunction

    // Owner keeps the bus while it requests; no preemption mid-burst
    always @* begin
        if ((grant_reg & i_req) != {N{1'b0}}) begin
            grant_next = grant_reg;
        end else begin
            grant_next = pick(i_req);
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            grant_reg <= {N{1'b0}};
        end else if (i_ce) begin
            grant_reg <= grant_next;
        end
    end

    assign o_grant = grant_reg;
endmodule // mrd_arbiter

// ### testbench/mrd_rx_dma_props.sv
// Checker of bus-master rules at the engine ports.
`timescale 1ns/1ps
module mrd_rx_dma_props (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [5:0] i_tx_fifo_space,
    input wire i_tx_next_short,
    input wire i_hready,
    input wire o_tx_data_req,
    input wire [2:0] o_tx_grant,
    input wire [1:0] o_htrans,
    input wire [31:0] o_haddr,
    input wire [2:0] o_hburst,
    input wire [2:0] o_hsize,
    input wire o_hbusreq
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Beats after NONSEQ; 3 bits so a fifth beat still shows
    reg [2:0] beat_reg;
    always @(posedge i_clk_sys) begin
        if (!i_rst_n || (o_htrans == 2'h2 && i_hready)) beat_reg <= 3'h0;
        else if (o_htrans == 2'h3 && i_hready) beat_reg <= beat_reg + 3'h1;
    end
    property p_size; o_htrans != 2'h0 |-> o_hsize == 3'h2; endproperty
    a_size: assert property (p_size) else $error("transfer not word sized");
    property p_kind; o_htrans == 2'h2 |-> o_hburst inside {3'h0, 3'h1, 3'h3}; endproperty
    a_kind: assert property (p_kind) else $error("bad burst kind");
    property p_incr; o_htrans == 2'h3 && $past(i_hready) |-> o_haddr == $past(o_haddr) + 32'h4;
    endproperty
    a_incr: assert property (p_incr) else $error("burst address not incrementing");
    property p_align; o_htrans == 2'h2 && o_hburst == 3'h3 |-> o_haddr[3:0] == 4'h0; endproperty
    a_align: assert property (p_align) else $error("four beat burst misaligned");
    property p_cross; o_htrans == 2'h3 |-> o_haddr[3:2] != 2'h0; endproperty
    a_cross: assert property (p_cross) else $error("burst crosses boundary");
    property p_beats; beat_reg <= 3'h3; endproperty
    a_beats: assert property (p_beats) else $error("burst longer than four");
    property p_txreq;
        o_tx_data_req == (i_tx_next_short ? i_tx_fifo_space >= 6'h1B : i_tx_fifo_space >= 6'h04);
    endproperty
    a_txreq: assert property (p_txreq) else $error("tx request threshold wrong");
    property p_busreq; o_htrans != 2'h0 |-> o_hbusreq; endproperty
    a_busreq: assert property (p_busreq) else $error("transfer without bus request");
    property p_grant; $onehot0(o_tx_grant); endproperty
    a_grant: assert property (p_grant) else $error("two tx grants at once");
    c_incr4: cover property (o_htrans == 2'h2 && o_hburst == 3'h3);
    c_single: cover property (o_htrans == 2'h2 && o_hburst == 3'h0);
    c_grant: cover property (o_tx_grant != 3'h0);
endmodule // mrd_rx_dma_props
bind mrd_rx_dma mrd_rx_dma_props u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_tx_fifo_space(i_tx_fifo_space), .i_tx_next_short(i_tx_next_short), .i_hready(i_hready),
    .o_tx_data_req(o_tx_data_req), .o_tx_grant(o_tx_grant), .o_htrans(o_htrans),
    .o_haddr(o_haddr), .o_hburst(o_hburst), .o_hsize(o_hsize), .o_hbusreq(o_hbusreq));

// ### testbench/mrd_ahb_mem.sv
// System bus memory model with optional wait states.
`timescale 1ns/1ps
module mrd_ahb_mem (
    input wire i_clk_sys,
    input wire i_slow,
    input wire [1:0] i_htrans,
    input wire [31:0] i_haddr,
    input wire i_hwrite,
    input wire [31:0] i_hwdata,
    output wire o_hgrant,
    output reg o_hready,
    output wire [1:0] o_hresp,
    output wire [31:0] o_hrdata
);
    reg [31:0] mem [0:127]; // Two-word descriptors, word 0 address and flags
    reg [6:0] dp_addr_reg = 7'h00;
    reg dp_wr_reg = 1'b0;
    reg dp_rd_reg = 1'b0;
    reg [31:0] junk_reg = 32'h5A5A5A5A;
    assign o_hgrant = 1'b1; // Grant at once, far inside the latency bound
    assign o_hresp = 2'h0;
    // Junk toggles so stale read data never looks valid
    assign o_hrdata = (dp_rd_reg && o_hready) ? mem[dp_addr_reg] : junk_reg;
    initial o_hready = 1'b1;
    always @(posedge i_clk_sys) begin
        junk_reg <= ~junk_reg;
        o_hready <= i_slow ? ~o_hready : 1'b1;
        if (o_hready) begin
            if (dp_wr_reg) mem[dp_addr_reg] <= i_hwdata;
            dp_wr_reg <= i_htrans[1] & i_hwrite;
            dp_rd_reg <= i_htrans[1] & ~i_hwrite;
            dp_addr_reg <= i_haddr[8:2];
        end
    end
endmodule // mrd_ahb_mem

// ### testbench/mrd_rx_dma_tb.sv
// Self-checking bench for the receive DMA engine.
`timescale 1ns/1ps
module mrd_rx_dma_tb;
    reg clk = 1'b0;
    reg rst_n, rd, wr, vld, lst, sh, trd, twr, slow;
    reg [3:0] adr;
    reg [31:0] wd, rw, q;
    reg [13:0] ln;
    reg [15:0] st;
    reg [5:0] sp;
    wire [31:0] rdat, hrd, ha, hwd;
    wire wt, rdy, tdr, hg, hr, breq, hw;
    wire [1:0] offs, hresp, ht;
    wire [2:0] gnt, hb, hs;
    int mismatches = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    mrd_rx_dma dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_rx_word_valid(vld), .i_rx_word(rw), .i_rx_word_last(lst),
        .i_rx_frame_len(ln), .i_rx_addr_status(st), .o_rx_word_ready(rdy), .o_rx_offset(offs),
        .i_tx_fifo_space(sp), .i_tx_next_short(sh), .i_tx_data_busy(1'b0),
        .i_tx_desc_rd_req(trd), .i_tx_desc_wr_req(twr), .o_tx_data_req(tdr), .o_tx_grant(gnt),
        .i_hgrant(hg), .i_hready(hr), .i_hresp(hresp), .i_hrdata(hrd), .o_hbusreq(breq),
        .o_htrans(ht), .o_haddr(ha), .o_hwrite(hw), .o_hburst(hb), .o_hsize(hs), .o_hwdata(hwd));
    mrd_ahb_mem u_mem (.i_clk_sys(clk), .i_slow(slow), .i_htrans(ht), .i_haddr(ha),
        .i_hwrite(hw), .i_hwdata(hwd), .o_hgrant(hg), .o_hready(hr), .o_hresp(hresp),
        .o_hrdata(hrd));
    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input string n, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task final_report;
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task send(input int n, input [13:0] l, input [15:0] s, input [7:0] f);
        for (int i = 0; i < n; i++) begin
            vld <= 1'b1;
            rw <= {f, 24'(i)};
            lst <= (i == n - 1);
            ln <= l;
            st <= s;
            @(negedge clk);
            while (rdy !== 1'b1) @(negedge clk);
            @(posedge clk);
        end
        vld <= 1'b0;
        lst <= 1'b0;
    endtask
    // Polls a status flag, then clears it by writing one
    task wait_flag(input int b);
        q = 32'h0;
        for (int k = 0; k < 300 && q[b] !== 1'b1; k++) bus(1'b0, 4'h8, 32'h0);
        chk("status flag", 32'h1, 32'(q[b]));
        bus(1'b1, 4'h8, 32'h1 << b);
    endtask
    task g_chk(input [2:0] e);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("tx grant", 32'(e), 32'(gnt));
        @(posedge clk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs;
        bus(1'b0, 4'h0, 32'h0);
        chk("config reset", 32'h0, q);
        bus(1'b1, 4'h4, 32'h43);
        bus(1'b0, 4'h4, 32'h0);
        chk("queue pointer", 32'h40, q);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask
    task t_tx;
        for (int k = 0; k < 4; k++) begin
            sh <= ~k[1];
            sp <= k[1] ? 6'h03 + k[0] : 6'h1A + k[0];
            @(negedge clk);
            chk("tx request", 32'(k[0]), 32'(tdr));
            @(posedge clk);
        end
        trd <= 1'b1;
        twr <= 1'b1;
        g_chk(3'h1);
        sp <= 6'h00;
        g_chk(3'h2);
        trd <= 1'b0;
        g_chk(3'h4);
        twr <= 1'b0;
    endtask
    task t_frame1;
        bus(1'b1, 4'h0, 32'h1);
        send(8, 14'h0020, 16'hF900, 8'hA1);
        wait_flag(2);
        chk("desc0 word0", 32'h81, u_mem.mem[16]);
        chk("desc0 status", 32'hF100C020, u_mem.mem[17]);
        for (int i = 0; i < 8; i++) chk("buffer", {8'hA1, 24'(i)}, u_mem.mem[32 + i]);
        bus(1'b0, 4'h4, 32'h0);
        chk("queue pointer", 32'h48, q);
    endtask
    // Offset frame over two buffers, wrapping back to a freed entry
    task t_frame2;
        slow <= 1'b1;
        bus(1'b1, 4'h0, 32'h8001);
        chk("offset pins", 32'h2, 32'(offs));
        u_mem.mem[16] = 32'h80;
        send(34, 14'h0086, 16'h1200, 8'hB2);
        wait_flag(2);
        chk("desc1 word0", 32'h103, u_mem.mem[18]);
        chk("desc1 status", 32'h6000, u_mem.mem[19]);
        chk("wrapped word0", 32'h81, u_mem.mem[16]);
        chk("final status", 32'h12008086, u_mem.mem[17] & 32'hFFFFCFFF);
        chk("first word", 32'hB2000000, u_mem.mem[64]);
        chk("last word", 32'hB2000021, u_mem.mem[33]);
        bus(1'b0, 4'h4, 32'h0);
        chk("queue pointer", 32'h48, q);
        slow <= 1'b0;
    endtask
    task t_noown;
        send(4, 14'h0010, 16'h0000, 8'hC3);
        wait_flag(0);
        chk("used buffer kept", 32'hB2000000, u_mem.mem[64]);
    endtask
    initial begin
        {rst_n, rd, wr, vld, lst, sh, trd, twr, slow} = 9'h000;
        {adr, wd, rw, ln, st, sp, q} = 0;
        u_mem.mem[16] = 32'h80;
        u_mem.mem[17] = 32'h0;
        u_mem.mem[18] = 32'h102;
        u_mem.mem[19] = 32'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_tx;
        t_frame1;
        t_frame2;
        t_noown;
        final_report;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        final_report;
    end
endmodule // mrd_rx_dma_tb
